// *** hdl/mbd_pkg.sv ***
// Constants, types and state layout for the memory board decode block
package mbd_pkg;
   // ----------------------------------------
   // Bus widths and field positions
   // ----------------------------------------
   localparam int ADDR_W = 24;
   localparam int IO_W = 16;
   localparam int SEL_W = 9;
   localparam int BANK_W = 4;
   localparam int BANK_HI = 23;
   localparam int BANK_LO = 20;
   localparam int REGION_HI = 19;
   localparam int REGION_LO = 16;
   localparam int PART_HI = 15;
   localparam int PART_LO = 14;
   localparam int EPROM_HI = 17;
   localparam int EPROM_LO = 16;
   localparam int EPROM_TOP_HI = 19;
   localparam int EPROM_TOP_LO = 18;
   // ----------------------------------------
   // Decode map
   // ----------------------------------------
   localparam logic [3:0] SRAM_REGION = 4'h0;
   localparam logic [3:0] NVRAM_REGION = 4'h1;
   localparam logic [1:0] EPROM_TOP = 2'h3;
   localparam logic [3:0] BANK_NONE = 4'h0;
   localparam int SRAM_SEL = 8;
   localparam int NVRAM_SEL_LO = 4;
   localparam int EPROM_SEL_LO = 0;
   // ----------------------------------------
   // I/O registers
   // ----------------------------------------
   localparam logic [15:0] IO_DIAG_ROUTE = 16'h8020;
   localparam logic [15:0] IO_CFG_READBACK = 16'h8040;
   localparam int DIAG_EN_BIT = 0;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int MCLK_HZ = 40_000_000;
   localparam int SLOW_LIMIT_HZ = 8_000_000;
   localparam int CNT_W = 4;
   // ----------------------------------------
   // Wait state machine and state layout
   // ----------------------------------------
   typedef enum logic [1:0] {
      MBD_IDLE = 2'b00,
      MBD_WAIT = 2'b01,
      MBD_DONE = 2'b10
   } mbd_wait_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [SEL_W-1:0] sel;
      logic buf_en;
      logic ready;
      logic [CNT_W-1:0] cnt;
      mbd_wait_t wstate;
      logic diag_route;
      logic diag_line;
      logic early_ale;
      logic early_wr;
      logic early_rd;
      logic [BANK_W-1:0] bank;
      logic [7:0] rdata;
      logic rdata_oe;
   } mbd_state_t;
endpackage : mbd_pkg

// *** hdl/mbd_decode.sv ***
// Memory board address latch, select decode, wait states and diagnostics
// Behaviour
// - Upper address decodes into five RAM and four EPROM selects.
// - Top RAM select enables static RAM, other four enable NVRAM.
// - Selects pass a register: loaded each clock while ALE high, held while low.
// - Select latch outputs are always enabled.
// - Jumper makes bits 20 to 23 bank lines or plain address.
// - Address latched and held until the bus cycle ends.
// - Select logic also yields the memory data buffer enable.
// - Each byte-pair has its own latched select; address is shared.
// - Data buffers enable only when all their enables are high.
// - Above the slow clock limit, ready is pulled low to stretch cycles.
// - Early address latch, memory write and read strobes are produced.
// - Writing one to diag address routes ready to the measure line.
// - I/O read at readback address returns straps and bank lines.
// - One readback bit flags backup battery at warning level.
module mbd_decode #(
   parameter int CPU_CLK_HZ = mbd_pkg::MCLK_HZ,
   parameter logic [3:0] WAIT_STATES = 4'h2,
   parameter int BATT_BIT = 7,
   parameter int STRAP_LSB = 4,
   parameter int STRAP_W = 3,
   parameter int BANK_LSB = 0
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Processor bus
   input wire logic [mbd_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_ale,
   input wire logic i_mem_rd,
   input wire logic i_mem_wr,
   input wire logic i_io_rd,
   input wire logic i_io_wr,
   input wire logic [7:0] i_io_wdata,
   // Straps and battery
   input wire logic i_bank_jumper,
   input wire logic [STRAP_W-1:0] i_cfg_straps,
   input wire logic i_batt_low,
   // Memory side
   output logic [mbd_pkg::ADDR_W-1:0] o_latched_addr,
   output logic [3:0] o_eprom_pair_selects,
   output logic [3:0] o_nvram_pair_selects,
   output logic o_sram_pair_select,
   output logic o_sel_oe,
   output logic o_data_buf_en,
   output logic [mbd_pkg::BANK_W-1:0] o_bank_lines,
   // Bus control and diagnostics
   output logic o_bus_ready_line,
   output logic o_diag_measure_line,
   output logic o_early_addr_strobe,
   output logic o_early_mem_write,
   output logic o_early_mem_read,
   // I/O readback
   output logic [7:0] o_io_rdata,
   output logic o_io_rdata_oe
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   mbd_pkg::mbd_state_t st;
   mbd_pkg::mbd_state_t next_st;
   logic need_wait;
   logic [mbd_pkg::SEL_W-1:0] dec_sel;
   logic bank_ok;
   logic mem_cmd;
   logic mem_start;
   logic [7:0] rb_byte;

   assign need_wait = (CPU_CLK_HZ > mbd_pkg::SLOW_LIMIT_HZ);
   assign mem_cmd = i_mem_rd | i_mem_wr;
   assign mem_start = mem_cmd & ~(st.early_rd | st.early_wr);

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   always_comb begin
      dec_sel = '0;
      bank_ok = i_bank_jumper | (i_addr[mbd_pkg::BANK_HI:mbd_pkg::BANK_LO] == mbd_pkg::BANK_NONE);
      if (bank_ok) begin
         if (i_addr[mbd_pkg::EPROM_TOP_HI:mbd_pkg::EPROM_TOP_LO] == mbd_pkg::EPROM_TOP) begin
            dec_sel[mbd_pkg::EPROM_SEL_LO + 32'(i_addr[mbd_pkg::EPROM_HI:mbd_pkg::EPROM_LO])] = 1'b1;
         end else if (i_addr[mbd_pkg::REGION_HI:mbd_pkg::REGION_LO] == mbd_pkg::NVRAM_REGION) begin
            dec_sel[mbd_pkg::NVRAM_SEL_LO + 32'(i_addr[mbd_pkg::PART_HI:mbd_pkg::PART_LO])] = 1'b1;
         end else if (i_addr[mbd_pkg::REGION_HI:mbd_pkg::REGION_LO] == mbd_pkg::SRAM_REGION) begin
            dec_sel[mbd_pkg::SRAM_SEL] = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Readback byte
   // ----------------------------------------
   always_comb begin
      rb_byte = mbd_pkg::RDATA_RESET;
      for (int i = 0; i < STRAP_W; i++) begin
         rb_byte[STRAP_LSB + i] = i_cfg_straps[i];
      end
      for (int i = 0; i < mbd_pkg::BANK_W; i++) begin
         rb_byte[BANK_LSB + i] = st.bank[i];
      end
      rb_byte[BATT_BIT] = i_batt_low;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      if (i_ale) begin
         next_st.addr = i_addr;
         next_st.bank = i_bank_jumper ? i_addr[mbd_pkg::BANK_HI:mbd_pkg::BANK_LO]
                                      : mbd_pkg::BANK_NONE;
      end
      if (i_ale) begin
         next_st.sel = dec_sel;
      end
      next_st.early_ale = i_ale;
      next_st.early_wr = i_mem_wr;
      next_st.early_rd = i_mem_rd;
      next_st.buf_en = (|st.sel) & mem_cmd;
      case (st.wstate)
         mbd_pkg::MBD_IDLE: begin
            next_st.ready = 1'b1;
            if (mem_start && need_wait && (|st.sel) && (WAIT_STATES != 4'h0)) begin
               next_st.wstate = mbd_pkg::MBD_WAIT;
               next_st.ready = 1'b0;
               next_st.cnt = WAIT_STATES - 4'h1;
            end
         end
         mbd_pkg::MBD_WAIT: begin
            if (st.cnt == 4'h0) begin
               next_st.wstate = mbd_pkg::MBD_DONE;
               next_st.ready = 1'b1;
            end else begin
               next_st.cnt = st.cnt - 4'h1;
            end
         end
         mbd_pkg::MBD_DONE: begin
            if (!mem_cmd) begin
               next_st.wstate = mbd_pkg::MBD_IDLE;
            end
         end
         default: begin
            next_st.wstate = mbd_pkg::MBD_IDLE;
            next_st.ready = 1'b1;
         end
      endcase
      if (i_io_wr && (i_addr[mbd_pkg::IO_W-1:0] == mbd_pkg::IO_DIAG_ROUTE)) begin
         next_st.diag_route = i_io_wdata[mbd_pkg::DIAG_EN_BIT];
      end
      next_st.diag_line = st.diag_route & st.ready;
      next_st.rdata_oe = i_io_rd && (i_addr[mbd_pkg::IO_W-1:0] == mbd_pkg::IO_CFG_READBACK);
      next_st.rdata = next_st.rdata_oe ? rb_byte : mbd_pkg::RDATA_RESET;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         st <= '0;
         st.ready <= 1'b1;
         st.wstate <= mbd_pkg::MBD_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_latched_addr = st.addr;
   assign o_eprom_pair_selects = st.sel[mbd_pkg::EPROM_SEL_LO +: 4];
   assign o_nvram_pair_selects = st.sel[mbd_pkg::NVRAM_SEL_LO +: 4];
   assign o_sram_pair_select = st.sel[mbd_pkg::SRAM_SEL];
   assign o_sel_oe = 1'b1;
   assign o_data_buf_en = st.buf_en;
   assign o_bank_lines = st.bank;
   assign o_bus_ready_line = st.ready;
   assign o_diag_measure_line = st.diag_line;
   assign o_early_addr_strobe = st.early_ale;
   assign o_early_mem_write = st.early_wr;
   assign o_early_mem_read = st.early_rd;
   assign o_io_rdata = st.rdata;
   assign o_io_rdata_oe = st.rdata_oe;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   property p_sel_onehot;
      $onehot0(st.sel);
   endproperty
   a_sel_onehot: assert property (p_sel_onehot) else $error("more than one select");

   property p_sram_sel;
      i_ale && bank_ok && (i_addr[19:16] == 4'h0) |=> o_sram_pair_select && !(|o_nvram_pair_selects);
   endproperty
   a_sram_sel: assert property (p_sram_sel) else $error("sram select missing");

   property p_sel_hold;
      !i_ale |=> $stable(st.sel);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select changed while held");

   property p_sel_oe;
      o_sel_oe;
   endproperty
   a_sel_oe: assert property (p_sel_oe) else $error("select outputs not enabled");

   property p_bank;
      i_ale && i_bank_jumper |=> o_bank_lines == $past(i_addr[23:20]);
   endproperty
   a_bank: assert property (p_bank) else $error("bank lines wrong");

   property p_addr_hold;
      i_ale ##1 !i_ale |-> o_latched_addr == $past(i_addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address not held");

   property p_buf_en;
      o_data_buf_en |-> $past(mem_cmd) && ($past(st.sel) != '0);
   endproperty
   a_buf_en: assert property (p_buf_en) else $error("buffer enabled wrongly");

   property p_wait;
      (st.wstate == mbd_pkg::MBD_IDLE) && mem_start && need_wait && (|st.sel)
         && (WAIT_STATES != 4'h0) |=> !o_bus_ready_line ##[1:16] o_bus_ready_line;
   endproperty
   a_wait: assert property (p_wait) else $error("wait not inserted");

   property p_early;
      i_ale && i_mem_rd |=> o_early_addr_strobe && o_early_mem_read;
   endproperty
   a_early: assert property (p_early) else $error("early strobe missing");

   property p_diag;
      st.diag_route |=> o_diag_measure_line == $past(o_bus_ready_line);
   endproperty
   a_diag: assert property (p_diag) else $error("diag line not routed");

   property p_readback;
      i_io_rd && (i_addr[mbd_pkg::IO_W-1:0] == mbd_pkg::IO_CFG_READBACK)
         |=> o_io_rdata_oe && o_io_rdata[BATT_BIT] == $past(i_batt_low);
   endproperty
   a_readback: assert property (p_readback) else $error("readback wrong");

   property p_addr_stable;
      !i_ale |=> $stable(o_latched_addr);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address moved");

   property p_refused;
      i_ale && !bank_ok |=> (st.sel == '0);
   endproperty
   a_refused: assert property (p_refused) else $error("select on foreign bank");

   property p_nvram_sel;
      i_ale && bank_ok
         && (i_addr[mbd_pkg::REGION_HI:mbd_pkg::REGION_LO] == mbd_pkg::NVRAM_REGION)
         |=> (|o_nvram_pair_selects) && !o_sram_pair_select;
   endproperty
   a_nvram_sel: assert property (p_nvram_sel) else $error("nvram select missing");

   property p_eprom_sel;
      i_ale && bank_ok
         && (i_addr[mbd_pkg::EPROM_TOP_HI:mbd_pkg::EPROM_TOP_LO] == mbd_pkg::EPROM_TOP)
         |=> (|o_eprom_pair_selects);
   endproperty
   a_eprom_sel: assert property (p_eprom_sel) else $error("eprom select missing");

   property p_buf_on;
      mem_cmd && (st.sel != '0) |=> o_data_buf_en;
   endproperty
   a_buf_on: assert property (p_buf_on) else $error("buffer not enabled");

   property p_ready_idle;
      (st.wstate == mbd_pkg::MBD_IDLE) && !mem_start |=> o_bus_ready_line;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("ready low when idle");

   property p_early_wr;
      i_mem_wr |=> o_early_mem_write;
   endproperty
   a_early_wr: assert property (p_early_wr) else $error("early write missing");

   property p_rb_quiet;
      !(i_io_rd && (i_addr[mbd_pkg::IO_W-1:0] == mbd_pkg::IO_CFG_READBACK))
         |=> !o_io_rdata_oe && (o_io_rdata == mbd_pkg::RDATA_RESET);
   endproperty
   a_rb_quiet: assert property (p_rb_quiet) else $error("readback without read");

   property p_diag_off;
      !st.diag_route |=> !o_diag_measure_line;
   endproperty
   a_diag_off: assert property (p_diag_off) else $error("diag line not idle");
endmodule : mbd_decode

// *** bench/mbd_cpu_model.sv ***
// Processor bus master model driving the memory board decode block
module mbd_cpu_model (
   // Clock and ready
   input wire logic i_mclk,
   input wire logic i_ready,
   // Processor bus
   output logic [23:0] o_addr,
   output logic o_ale,
   output logic o_mem_rd,
   output logic o_mem_wr,
   output logic o_io_rd,
   output logic o_io_wr,
   output logic [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {o_addr, o_ale, o_mem_rd, o_mem_wr, o_io_rd, o_io_wr, o_wdata} = '0;
   end
   task automatic mem_cycle(input logic [23:0] a, input logic wr, output int waits);
      int k;
      waits = 0;
      @(posedge i_mclk);
      o_addr <= a;
      o_ale <= 1'b1;
      @(posedge i_mclk);
      o_ale <= 1'b0;
      o_mem_wr <= wr;
      o_mem_rd <= !wr;
      @(posedge i_mclk);
      for (k = 0; k < 20; k++) begin
         @(posedge i_mclk);
         if (i_ready === 1'b0) waits++;
         else if (waits > 0 || k > 3) break;
      end
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
   endtask : mem_cycle
   task automatic io(input logic [15:0] a, input logic wr, input logic [7:0] d);
      @(posedge i_mclk);
      o_addr <= {8'h00, a};
      o_io_wr <= wr;
      o_io_rd <= !wr;
      o_wdata <= d;
      @(posedge i_mclk);
      o_io_wr <= 1'b0;
      o_io_rd <= 1'b0;
      o_wdata <= ~d;
   endtask : io
endmodule : mbd_cpu_model

// *** bench/tb_mbd_decode.sv ***
// Self-checking bench for the memory board decode block
module tb_mbd_decode;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk, i_reset, i_bank_jumper, i_batt_low, bus_ready, diag, oe, ale_q, rp;
   logic [2:0] i_cfg_straps;
   logic [23:0] addr, laddr;
   logic ale, mrd, mwr, iord, iowr, ssel, soe, bufen, eale, ewr, erd;
   logic [7:0] wdata, rdata;
   logic [3:0] esel, nsel, bank, last_bank;
   logic [37:0] sel_q[$];
   logic [7:0] rd_q[$];
   logic [31:0] rng;
   int bad_count, tests_run, w, i, dg;
   int cyc = 0;
   logic [3:0] ctl_q;
   logic sel_any = 1'b0;
   logic [23:0] map_addr [10] = '{24'h000000, 24'h014000, 24'h01C000, 24'h0C0000, 24'h0D4000,
      24'h0E0000, 24'h0F0000, 24'h050000, 24'h100000, 24'h3C0000};
   mbd_cpu_model cpu (.i_mclk(i_mclk), .i_ready(bus_ready), .o_addr(addr), .o_ale(ale),
      .o_mem_rd(mrd), .o_mem_wr(mwr), .o_io_rd(iord), .o_io_wr(iowr), .o_wdata(wdata));
   mbd_decode uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(addr), .i_ale(ale),
      .i_mem_rd(mrd), .i_mem_wr(mwr), .i_io_rd(iord), .i_io_wr(iowr), .i_io_wdata(wdata),
      .i_bank_jumper(i_bank_jumper), .i_cfg_straps(i_cfg_straps), .i_batt_low(i_batt_low),
      .o_latched_addr(laddr), .o_eprom_pair_selects(esel), .o_nvram_pair_selects(nsel),
      .o_sram_pair_select(ssel), .o_sel_oe(soe), .o_data_buf_en(bufen), .o_bank_lines(bank),
      .o_bus_ready_line(bus_ready), .o_diag_measure_line(diag), .o_early_addr_strobe(eale),
      .o_early_mem_write(ewr), .o_early_mem_read(erd), .o_io_rdata(rdata), .o_io_rdata_oe(oe));
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   function automatic logic [12:0] dec(logic [23:0] a, logic j);
      logic [8:0] s;
      s = 9'h000;
      if (j || a[23:20] == 4'h0) begin
         if (a[19:18] == 2'h3) s[a[17:16]] = 1'b1;
         else if (a[19:16] == 4'h1) s[4 + a[15:14]] = 1'b1;
         else if (a[19:16] == 4'h0) s[8] = 1'b1;
      end
      return {j ? a[23:20] : 4'h0, s};
   endfunction : dec
   task automatic chk(logic [37:0] got, logic [37:0] exp, string m);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task automatic mem(logic [23:0] a, logic j);
      logic [12:0] e;
      @(posedge i_mclk);
      i_bank_jumper <= j;
      e = dec(a, j);
      last_bank = e[12:9];
      sel_any <= |e[8:0];
      sel_q.push_back({1'b1, a, e});
      cpu.mem_cycle(a, rng[3], w);
      chk(w, (e[8:0] != 0) ? 2 : 0, "wait states");
      rng = xs(rng);
   endtask : mem
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      ale_q <= ale;
      rp <= bus_ready;
      ctl_q <= {ale, mwr, mrd, (mrd | mwr) & sel_any};
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         close_out();
      end
   end
   // Result watcher
   always @(negedge i_mclk) begin
      if (ale_q && sel_q.size() > 0)
         chk({soe, laddr, bank, ssel, nsel, esel}, sel_q.pop_front(), "selects");
      if (oe) begin
         if (rd_q.size() == 0) chk(1, 0, "stray readback");
         else chk(rdata, rd_q.pop_front(), "readback");
      end
      if (dg < 2) chk(diag, dg ? rp : 1'b0, "diag line");
      chk({eale, ewr, erd}, ctl_q[3:1], "early strobes");
      chk(bufen, ctl_q[0], "buffer enable");
   end
   initial begin
      {i_reset, i_cfg_straps} = '1;
      {bad_count, tests_run, dg, i_batt_low, i_bank_jumper} = '0;
      rng = 32'h000040A0;
      repeat (3) @(posedge i_mclk);
      i_reset <= 1'b0;
      for (i = 0; i < 10; i++) mem(map_addr[i], i > 8);
      for (i = 0; i < 12; i++) mem(rng[23:0], rng[7]);
      $display("decode test done");
      dg = 2;
      cpu.io(16'h8021, 1'b1, 8'h01);
      repeat (2) @(posedge i_mclk);
      dg = 0;
      mem(24'h000000, 1'b0);
      dg = 2;
      cpu.io(16'h8020, 1'b1, 8'h01);
      repeat (2) @(posedge i_mclk);
      dg = 1;
      mem(24'h0C0000, 1'b0);
      dg = 2;
      cpu.io(16'h8020, 1'b1, 8'h00);
      repeat (2) @(posedge i_mclk);
      dg = 0;
      $display("diag test done");
      for (i = 0; i < 6; i++) begin
         i_cfg_straps <= rng[2:0];
         i_batt_low <= rng[5];
         rd_q.push_back({rng[5], rng[2:0], last_bank});
         cpu.io(16'h8040, 1'b0, 8'h00);
         cpu.io(16'h8041, 1'b0, 8'h00);
         rng = xs(rng);
      end
      repeat (3) @(posedge i_mclk);
      chk(sel_q.size() + rd_q.size(), 0, "leftover");
      $display("readback test done");
      close_out();
   end
endmodule : tb_mbd_decode
